/* src/phy_lm_defs.svh */
// Register offsets, field positions, reset values and timing counts of the PHY control block.
`ifndef PHY_LM_DEFS_SVH
`define PHY_LM_DEFS_SVH
`define OFF_BASIC_CTRL      4'h0
`define OFF_BASIC_STAT      4'h1
`define OFF_CABLE_TEST      4'h2
`define OFF_IRQ_STAT        4'h3
`define OFF_IRQ_MASK        4'h4
`define OFF_MODE_CTRL       4'h5
`define BIT_SOFT_RESET      15
`define BIT_AN_ENABLE       12
`define BIT_POWER_DOWN      11
`define BIT_LINK_STATUS     2
`define BIT_CT_ENABLE       15
`define BIT_CT_DONE         14
`define BIT_CROSSOVER_STATE 13
`define BIT_AUTO_CROSSOVER  15
`define BIT_FIBER_MODE      14
`define CT_LEN_MSB          7
`define RST_BASIC_CTRL      16'h3000
`define RST_MODE_CTRL       16'h8000
`define IRQ_LINK_UP         0
`define IRQ_LINK_DOWN       1
`define IRQ_CT_DONE         2
`define IRQ_RESET_DONE      3
`define IRQ_BITS            4
`define CLK_MHZ             100
`define STAB_TIME_MS        330
`define STAB_CYCLES         (`STAB_TIME_MS * 1000 * `CLK_MHZ)
`define RESET_CYCLES        32'd16
`define CT_TIMEOUT_CYCLES   8'hff
`endif

/* src/phy_lm_pkg.sv */
// Types shared by the PHY control block.
package phy_lm_pkg;
    typedef enum logic [1:0] {
        LINK_DOWN  = 2'b00,
        LINK_WAIT  = 2'b01,
        LINK_READY = 2'b10,
        LINK_UP    = 2'b11
    } link_state_t;
    typedef enum logic [1:0] {
        CT_IDLE  = 2'b00,
        CT_PULSE = 2'b01,
        CT_LISTEN = 2'b10,
        CT_DONE  = 2'b11
    } ct_state_t;
    typedef struct packed {
        logic       pulse_tx_pair;
        logic       pulse_rx_pair;
        logic       active;
    } ct_drive_t;
endpackage

/* src/phy_link_fsm.sv */
// Link integrity state machine with line stabilisation timer.
`timescale 1ns/1ns
`default_nettype none
`include "phy_lm_defs.svh"
module phy_link_fsm #(
    parameter int unsigned STAB_CYCLES = `STAB_CYCLES
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Line and control.
    input  wire logic signal_valid,
    input  wire logic an_enabled,
    input  wire logic an_link_enable,
    input  wire logic force_down,
    // Result.
    output logic      link_up,
    output phy_lm_pkg::link_state_t state
);
    phy_lm_pkg::link_state_t next_state;
    logic [31:0] timer;
    logic [31:0] next_timer;
    always_comb begin
        next_state = state;
        next_timer = timer;
        if (!signal_valid || force_down) begin
            next_state = phy_lm_pkg::LINK_DOWN;
            next_timer = 32'h0;
        end else begin
            case (state)
                phy_lm_pkg::LINK_DOWN: begin
                    next_state = phy_lm_pkg::LINK_WAIT;
                    next_timer = 32'h1;
                end
                phy_lm_pkg::LINK_WAIT: begin
                    if (timer >= STAB_CYCLES) begin
                        next_state = an_enabled ? phy_lm_pkg::LINK_READY : phy_lm_pkg::LINK_UP;
                    end else begin
                        next_timer = timer + 32'h1;
                    end
                end
                phy_lm_pkg::LINK_READY: begin
                    if (!an_enabled || an_link_enable) begin
                        next_state = phy_lm_pkg::LINK_UP;
                    end
                end
                phy_lm_pkg::LINK_UP: next_state = phy_lm_pkg::LINK_UP;
                default: next_state = phy_lm_pkg::LINK_DOWN;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state   <= phy_lm_pkg::LINK_DOWN;
            timer   <= 32'h0;
            link_up <= 1'b0;
        end else begin
            state   <= next_state;
            timer   <= next_timer;
            link_up <= (next_state == phy_lm_pkg::LINK_UP);
        end
    end
    property p_link_drop;
        @(posedge clk) disable iff (!resetn)
        !signal_valid |=> !link_up && state == phy_lm_pkg::LINK_DOWN;
    endproperty
    a_link_drop: assert property (p_link_drop) else $error("link kept after signal loss");
    property p_no_early_ready;
        @(posedge clk) disable iff (!resetn)
        $rose(state == phy_lm_pkg::LINK_READY) |-> timer >= STAB_CYCLES;
    endproperty
    a_no_early_ready: assert property (p_no_early_ready) else $error("ready too early");
    property p_ready_to_up;
        @(posedge clk) disable iff (!resetn)
        state == phy_lm_pkg::LINK_READY && an_link_enable && signal_valid && !force_down
            |=> state == phy_lm_pkg::LINK_UP;
    endproperty
    a_ready_to_up: assert property (p_ready_to_up) else $error("ready did not go up");
    property p_ready_waits;
        @(posedge clk) disable iff (!resetn)
        state == phy_lm_pkg::LINK_READY && an_enabled && !an_link_enable && signal_valid
            && !force_down |=> state == phy_lm_pkg::LINK_READY;
    endproperty
    a_ready_waits: assert property (p_ready_waits) else $error("ready left without enable");
    property p_no_an_skip;
        @(posedge clk) disable iff (!resetn)
        state == phy_lm_pkg::LINK_WAIT && timer >= STAB_CYCLES && !an_enabled && signal_valid
            && !force_down |=> state == phy_lm_pkg::LINK_UP;
    endproperty
    a_no_an_skip: assert property (p_no_an_skip) else $error("no direct link up");
    property p_timer_restart;
        @(posedge clk) disable iff (!resetn)
        !signal_valid |=> timer == 32'h0;
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");
endmodule
`default_nettype wire

/* src/phy_cable_test.sv */
// Cable reflection test sequencer: pulses a pair and times the echo.
`timescale 1ns/1ns
`default_nettype none
`include "phy_lm_defs.svh"
module phy_cable_test (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Control.
    input  wire logic start,
    input  wire logic crossover_state_bit,
    input  wire logic echo_seen,
    // Result.
    output phy_lm_pkg::ct_state_t state,
    output phy_lm_pkg::ct_drive_t drive,
    output logic [`CT_LEN_MSB:0]  channel_length,
    output logic                  done_pulse
);
    phy_lm_pkg::ct_state_t next_state;
    logic [`CT_LEN_MSB:0] count;
    logic [`CT_LEN_MSB:0] next_count;
    logic [`CT_LEN_MSB:0] next_length;
    always_comb begin
        next_state  = state;
        next_count  = count;
        next_length = channel_length;
        case (state)
            phy_lm_pkg::CT_IDLE: begin
                if (start) begin
                    next_state = phy_lm_pkg::CT_PULSE;
                end
            end
            phy_lm_pkg::CT_PULSE: begin
                next_state = phy_lm_pkg::CT_LISTEN;
                next_count = '0;
            end
            phy_lm_pkg::CT_LISTEN: begin
                if (echo_seen || count == `CT_TIMEOUT_CYCLES) begin
                    next_length = count;
                    next_state  = phy_lm_pkg::CT_DONE;
                end else begin
                    next_count = count + 8'h01;
                end
            end
            phy_lm_pkg::CT_DONE: next_state = phy_lm_pkg::CT_IDLE;
            default: next_state = phy_lm_pkg::CT_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state          <= phy_lm_pkg::CT_IDLE;
            count          <= '0;
            channel_length <= '0;
        end else begin
            state          <= next_state;
            count          <= next_count;
            channel_length <= next_length;
        end
    end
    // The pulse goes out on one pair only, chosen by the crossover state.
    always_comb begin
        drive.active        = (state != phy_lm_pkg::CT_IDLE);
        drive.pulse_tx_pair = (state == phy_lm_pkg::CT_PULSE) && !crossover_state_bit;
        drive.pulse_rx_pair = (state == phy_lm_pkg::CT_PULSE) && crossover_state_bit;
        done_pulse          = (state == phy_lm_pkg::CT_DONE);
    end
endmodule
`default_nettype wire

/* src/phy_link_monitor_reset_tdr.sv */
// PHY control: soft and power-down resets, link integrity and cable test, Avalon-MM registers.
`timescale 1ns/1ns
`default_nettype none
`include "phy_lm_defs.svh"
module phy_link_monitor_reset_tdr #(
    parameter int unsigned STAB_CYCLES = `STAB_CYCLES
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        resetn,
    // Avalon-MM slave.
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Line side.
    input  wire logic        signal_valid,
    input  wire logic        link_10m_status,
    input  wire logic        an_link_enable,
    input  wire logic        echo_seen,
    // Outputs.
    output logic             link_led,
    output logic             txrx_enable,
    output logic             pulse_tx_pair,
    output logic             pulse_rx_pair,
    output logic             phy_core_reset,
    output logic             irq
);
    logic [15:0] phy_basic_control_reg;
    logic [15:0] next_basic_control;
    logic [15:0] mode_ctrl;
    logic [15:0] next_mode_ctrl;
    logic        ct_enable;
    logic        next_ct_enable;
    logic        ct_done;
    logic        next_ct_done;
    logic [`IRQ_BITS-1:0] irq_stat;
    logic [`IRQ_BITS-1:0] next_irq_stat;
    logic [`IRQ_BITS-1:0] irq_mask;
    logic [`IRQ_BITS-1:0] next_irq_mask;
    logic [31:0] rst_count;
    logic [31:0] next_rst_count;
    logic        pd_prev;
    logic        ack;
    logic [31:0] next_readdata;
    logic        link_up_100;
    logic        link_up_prev;
    logic        combined_link;
    logic        ct_start;
    logic        ct_done_pulse;
    logic        ct_busy;
    logic        rst_active;
    logic        rst_done;
    logic        wr_low;
    logic        wr_high;
    logic [`CT_LEN_MSB:0] channel_length;
    phy_lm_pkg::link_state_t link_state;
    phy_lm_pkg::ct_state_t   ct_state;
    phy_lm_pkg::ct_drive_t   ct_drive;
    logic [`IRQ_BITS-1:0] irq_event;
    logic [15:0] phy_basic_status_reg;
    logic [15:0] cable_test_ctrl_stat_reg;
    // Core logic is held in reset while the reset counter runs; registers are not.
    assign rst_active = (rst_count != 32'h0);
    assign rst_done   = (rst_count == 32'h1);
    assign ct_busy    = ct_enable || (ct_state != phy_lm_pkg::CT_IDLE);
    phy_link_fsm #(
        .STAB_CYCLES (STAB_CYCLES)
    ) u_link (
        .clk            (clk),
        .resetn         (resetn && !rst_active),
        .signal_valid   (signal_valid),
        .an_enabled     (phy_basic_control_reg[`BIT_AN_ENABLE]),
        .an_link_enable (an_link_enable),
        .force_down     (ct_busy || phy_basic_control_reg[`BIT_POWER_DOWN]),
        .link_up        (link_up_100),
        .state          (link_state)
    );
    phy_cable_test u_ct (
        .clk                 (clk),
        .resetn              (resetn && !rst_active),
        .start               (ct_start),
        .crossover_state_bit (mode_ctrl[`BIT_CROSSOVER_STATE]),
        .echo_seen           (echo_seen),
        .state               (ct_state),
        .drive               (ct_drive),
        .channel_length      (channel_length),
        .done_pulse          (ct_done_pulse)
    );
    assign ct_start = ct_enable && (ct_state == phy_lm_pkg::CT_IDLE) && !ct_done;
    assign combined_link = link_up_100 || link_10m_status;
    assign phy_basic_status_reg = {13'h0, combined_link, 2'h0};
    assign cable_test_ctrl_stat_reg = {ct_enable, ct_done, 6'h0, channel_length};
    assign wr_low  = write && ack && byteenable[0];
    assign wr_high = write && ack && byteenable[1];
    assign irq_event = {rst_done, ct_done_pulse, link_up_prev && !link_up_100,
                        !link_up_prev && link_up_100};
    always_comb begin
        next_basic_control = phy_basic_control_reg;
        next_mode_ctrl     = mode_ctrl;
        next_ct_enable     = ct_enable;
        next_ct_done       = ct_done;
        next_irq_mask      = irq_mask;
        next_rst_count     = rst_count;
        next_readdata      = 32'h0;
        if (rst_active) begin
            next_rst_count = rst_count - 32'h1;
        end
        if (rst_done) begin
            next_basic_control[`BIT_SOFT_RESET] = 1'b0;
        end
        // Leaving power-down restarts the core without touching registers.
        if (pd_prev && !phy_basic_control_reg[`BIT_POWER_DOWN]) begin
            next_rst_count = `RESET_CYCLES;
        end
        if (ct_done_pulse) begin
            next_ct_enable = 1'b0;
            next_ct_done   = 1'b1;
        end
        // Read data is registered with the wait cycle so it stands at the accept edge.
        if (read && !ack) begin
            case (address)
                `OFF_BASIC_CTRL: next_readdata = {16'h0, phy_basic_control_reg};
                `OFF_BASIC_STAT: next_readdata = {16'h0, phy_basic_status_reg};
                `OFF_CABLE_TEST: next_readdata = {16'h0, cable_test_ctrl_stat_reg};
                `OFF_IRQ_STAT:   next_readdata = {28'h0, irq_stat};
                `OFF_IRQ_MASK:   next_readdata = {28'h0, irq_mask};
                `OFF_MODE_CTRL:  next_readdata = {16'h0, mode_ctrl};
                default:         next_readdata = 32'h0;
            endcase
        end
        if (write && ack) begin
            case (address)
                `OFF_BASIC_CTRL: begin
                    if (wr_low) begin
                        next_basic_control[7:0] = writedata[7:0];
                    end
                    if (wr_high) begin
                        next_basic_control[15:8] = writedata[15:8];
                        // Soft reset restarts the core only; straps are never reloaded.
                        if (writedata[`BIT_SOFT_RESET]) begin
                            next_rst_count = `RESET_CYCLES;
                        end
                    end
                end
                `OFF_CABLE_TEST: begin
                    if (wr_high && writedata[`BIT_CT_ENABLE]) begin
                        next_ct_enable = 1'b1;
                        next_ct_done   = 1'b0;
                    end
                end
                `OFF_IRQ_MASK: begin
                    if (wr_low) begin
                        next_irq_mask = writedata[`IRQ_BITS-1:0];
                    end
                end
                `OFF_MODE_CTRL: begin
                    if (wr_low) begin
                        next_mode_ctrl[7:0] = writedata[7:0];
                    end
                    if (wr_high) begin
                        next_mode_ctrl[15:8] = writedata[15:8];
                    end
                end
                default: next_mode_ctrl = mode_ctrl;
            endcase
        end
    end
    // A hardware event in the same cycle as a write-one clear keeps its bit set.
    always_comb begin
        next_irq_stat = irq_stat;
        if (wr_low && address == `OFF_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~writedata[`IRQ_BITS-1:0];
        end
        next_irq_stat = next_irq_stat | irq_event;
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            phy_basic_control_reg <= `RST_BASIC_CTRL;
            mode_ctrl             <= `RST_MODE_CTRL;
            ct_enable             <= 1'b0;
            ct_done               <= 1'b0;
            irq_stat              <= '0;
            irq_mask              <= '0;
            rst_count             <= 32'h0;
            pd_prev               <= 1'b0;
            ack                   <= 1'b0;
            waitrequest           <= 1'b1;
            readdata              <= 32'h0;
            link_up_prev          <= 1'b0;
            link_led              <= 1'b0;
            txrx_enable           <= 1'b0;
            pulse_tx_pair         <= 1'b0;
            pulse_rx_pair         <= 1'b0;
            phy_core_reset        <= 1'b0;
            irq                   <= 1'b0;
        end else begin
            phy_basic_control_reg <= next_basic_control;
            mode_ctrl             <= next_mode_ctrl;
            ct_enable             <= next_ct_enable;
            ct_done               <= next_ct_done;
            irq_stat              <= next_irq_stat;
            irq_mask              <= next_irq_mask;
            rst_count             <= next_rst_count;
            pd_prev               <= phy_basic_control_reg[`BIT_POWER_DOWN];
            ack                   <= (read || write) && !ack;
            waitrequest           <= !((read || write) && !ack);
            readdata              <= next_readdata;
            link_up_prev          <= link_up_100;
            link_led              <= combined_link;
            txrx_enable           <= link_up_100;
            pulse_tx_pair         <= ct_drive.pulse_tx_pair;
            pulse_rx_pair         <= ct_drive.pulse_rx_pair;
            phy_core_reset        <= (next_rst_count != 32'h0);
            irq                   <= |(next_irq_stat & next_irq_mask);
        end
    end
    // Each access takes two cycles: waitrequest drops in the cycle after the request.
    property p_soft_reset_clears;
        @(posedge clk) disable iff (!resetn)
        rst_done |=> !phy_basic_control_reg[`BIT_SOFT_RESET];
    endproperty
    a_soft_reset_clears: assert property (p_soft_reset_clears) else $error("soft reset stuck");
    property p_pd_exit_reset;
        @(posedge clk) disable iff (!resetn)
        pd_prev && !phy_basic_control_reg[`BIT_POWER_DOWN] |=> phy_core_reset;
    endproperty
    a_pd_exit_reset: assert property (p_pd_exit_reset) else $error("no reset on wake");
    property p_pd_keeps_mask;
        @(posedge clk) disable iff (!resetn)
        $fell(phy_basic_control_reg[`BIT_POWER_DOWN]) && !write |=> $stable(irq_mask)
            && $stable(mode_ctrl);
    endproperty
    a_pd_keeps_mask: assert property (p_pd_keeps_mask) else $error("registers changed");
    property p_led_combined;
        @(posedge clk) disable iff (!resetn)
        ##1 link_led == $past(link_up_100 || link_10m_status);
    endproperty
    a_led_combined: assert property (p_led_combined) else $error("led not combined");
    property p_ct_drops_link;
        @(posedge clk) disable iff (!resetn)
        ct_busy && !rst_active |=> !link_up_100;
    endproperty
    a_ct_drops_link: assert property (p_ct_drops_link) else $error("link up in test");
    property p_ct_done;
        @(posedge clk) disable iff (!resetn)
        ct_done_pulse |=> !ct_enable && ct_done && irq_stat[`IRQ_CT_DONE];
    endproperty
    a_ct_done: assert property (p_ct_done) else $error("test completion not flagged");
    property p_pair_select;
        @(posedge clk) disable iff (!resetn)
        ct_state == phy_lm_pkg::CT_PULSE |=> pulse_rx_pair == $past(mode_ctrl[`BIT_CROSSOVER_STATE])
            && pulse_tx_pair != pulse_rx_pair;
    endproperty
    a_pair_select: assert property (p_pair_select) else $error("wrong pair pulsed");
    property p_length_stable;
        @(posedge clk) disable iff (!resetn)
        ct_done && ct_state == phy_lm_pkg::CT_IDLE && !rst_active |=> $stable(channel_length);
    endproperty
    a_length_stable: assert property (p_length_stable) else $error("length moved");
endmodule
`default_nettype wire

/* test/link_partner.sv */
// Cable and remote link partner model for the PHY line side.
`timescale 1ns/1ns
`default_nettype none
module link_partner (
    // Clock.
    input  wire logic       clk,
    // Bench control.
    input  wire logic       line_on,
    input  wire logic       an_ok,
    input  wire logic       l10,
    input  wire logic [7:0] echo_dly,
    // Line side.
    input  wire logic       pulse_tx_pair,
    input  wire logic       pulse_rx_pair,
    output logic            signal_valid,
    output logic            link_10m_status,
    output logic            an_link_enable,
    output logic            echo_seen
);
    int cnt = -1;
    initial {signal_valid, link_10m_status, an_link_enable, echo_seen} = 4'h0;
    // One echo per pulse, so a design that pulses twice measures a wrong length.
    always @(posedge clk) begin
        signal_valid <= line_on;
        link_10m_status <= l10;
        an_link_enable <= an_ok && line_on;
        echo_seen <= (cnt == 0);
        if (pulse_tx_pair || pulse_rx_pair) cnt <= echo_dly;
        else if (cnt >= 0) cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the PHY link monitor, reset and cable test block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 0, resetn = 0, read = 0, write = 0, line_on = 0, an_ok = 0, l10 = 0;
    logic [3:0] address = 4'h0, byteenable = 4'hf;
    logic [31:0] writedata = 32'h0, readdata, rd, r, seed = 32'h6519c346;
    logic waitrequest, signal_valid, link_10m_status, an_link_enable, echo_seen;
    logic link_led, txrx_enable, pulse_tx_pair, pulse_rx_pair, phy_core_reset, irq;
    logic [7:0] echo_dly = 8'h10;
    int err_total = 0, check_count = 0, n, txc = 0, rxc = 0, t0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        txc += pulse_tx_pair;
        rxc += pulse_rx_pair;
    end
    phy_link_monitor_reset_tdr #(.STAB_CYCLES(20)) u_dut (.clk, .resetn, .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest, .signal_valid,
        .link_10m_status, .an_link_enable, .echo_seen, .link_led, .txrx_enable,
        .pulse_tx_pair, .pulse_rx_pair, .phy_core_reset, .irq);
    link_partner u_far (.clk, .line_on, .an_ok, .l10, .echo_dly, .pulse_tx_pair,
        .pulse_rx_pair, .signal_valid, .link_10m_status, .an_link_enable, .echo_seen);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Request is held until waitrequest is sampled low; read data is taken at that edge.
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin @(posedge clk); k++; end while (waitrequest !== 1'b0 && k < 50);
        rd = readdata;
        if (k >= 50) err_total++;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic wait_up();
        n = 0;
        while (txrx_enable !== 1'b1 && n < 300) begin cyc(1); n++; end
    endtask
    initial begin
        cyc(16);
        @(posedge clk);
        resetn <= 1;
        acc(0, 4'h0, 0); chk(rd, 32'h3000);
        acc(0, 4'h5, 0); chk(rd, 32'h8000);
        acc(0, 4'h6, 0); chk(rd, 0);
        acc(1, 4'h3, 32'hf);
        acc(1, 4'h4, 32'h1);
        line_on = 1;
        cyc(60); chk(txrx_enable, 0);
        an_ok = 1;
        cyc(5); chk(txrx_enable, 1);
        chk(link_led, 1);
        chk(irq, 1);
        acc(0, 4'h1, 0); chk(rd[2], 1);
        acc(1, 4'h4, 0); cyc(1); chk(irq, 0);
        acc(1, 4'h3, 32'h1); acc(0, 4'h3, 0); chk(rd[0], 0);
        line_on = 0;
        cyc(4); chk(txrx_enable, 0);
        chk(link_led, 0);
        acc(0, 4'h3, 0); chk(rd[1], 1);
        for (int i = 0; i < 4; i++) begin
            r = xs();
            l10 = r[0];
            cyc(4); chk(link_led, r[0]);
            acc(0, 4'h1, 0); chk(rd[2], r[0]);
        end
        l10 = 0;
        acc(1, 4'h0, 32'h2100);
        line_on = 1;
        cyc(15);
        line_on = 0;
        cyc(3);
        line_on = 1;
        wait_up(); chk(n >= 20 && n < 40, 1);
        for (int p = 0; p < 2; p++) begin
            r = xs();
            echo_dly = 8'h8 + r[3:0];
            acc(1, 4'h5, p << 13);
            txc = 0; rxc = 0;
            acc(1, 4'h2, 32'h8000);
            cyc(3); chk(txrx_enable, 0);
            n = 0;
            do begin acc(0, 4'h2, 0); n++; end while (rd[14] !== 1'b1 && n < 200);
            chk(rd[15:14], 2'b01);
            chk(rd[7:0] + 2 >= echo_dly && rd[7:0] <= echo_dly + 6, 1);
            chk({txc != 0, rxc != 0}, p ? 2'b01 : 2'b10);
            acc(0, 4'h3, 0); chk(rd[2], 1);
        end
        acc(1, 4'h0, 32'ha100);
        n = 0;
        while (phy_core_reset !== 1'b1 && n < 20) begin cyc(1); n++; end
        n = 0;
        while (phy_core_reset === 1'b1 && n < 40) begin cyc(1); n++; end
        chk(n, 16);
        acc(0, 4'h0, 0); chk(rd[15:12], 4'h2);
        acc(1, 4'h4, 32'h5);
        acc(1, 4'h0, 32'h2900);
        acc(1, 4'h0, 32'h2100);
        cyc(4); chk(phy_core_reset, 1);
        cyc(20);
        acc(0, 4'h4, 0); chk(rd, 32'h5);
        acc(0, 4'h0, 0); chk(rd, 32'h2100);
        wrap_up();
    end
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule
`default_nettype wire
